// ### irs_pkg.sv
package irs_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] BAUD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] MASK_OFF = 8'h0c;
  localparam logic [7:0] STATE_OFF = 8'h10;

  // Control bit positions
  localparam int CTRL_RSTART_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  // Status / mask bit positions
  localparam int ST_START_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_COLL_BIT = 2;
  localparam int ST_WIDTH = 3;

  localparam logic [7:0] BAUD_RESET = 8'h04;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [9:0] {
    IRS_IDLE = 10'h001,
    IRS_RS_SCL_LOW = 10'h002,
    IRS_RS_SDA_HIGH = 10'h004,
    IRS_RS_SCL_RISE = 10'h008,
    IRS_RS_BOTH_HIGH = 10'h010,
    IRS_RS_SDA_LOW = 10'h020,
    IRS_SP_SDA_LOW = 10'h040,
    IRS_SP_SCL_RISE = 10'h080,
    IRS_SP_COUNT = 10'h100,
    IRS_SP_SDA_REL = 10'h200
  } irs_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } irs_bus_t;

endpackage

// ### irs_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Repeated start begins only when idle
// - First drive SCL low
// - SCL low seen: load baud divider
// - Release SDA for one tick period
// - Timeout with SDA high releases SCL
// - SCL high seen: reload divider
// - Both lines high one full period
// - SDA low one period, then SCL low
// - Clear request, no reload, SDA low
// - Start seen on bus sets flag
// - Irq flag after final period expires
// - Request ignored while busy
// - SDA low at SCL rise: collision
// - SCL falls before SDA driven: collision
// - Stop: SDA low, release SCL, await
// - SCL high: load divider, count down
// - SDA low after stop count: collision
// - SCL low before SDA release: collision
module irs_top (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire irs_pkg::irs_bus_t bus_in_i,
  output irs_pkg::irs_bus_t bus_out_o,
  output irs_pkg::irs_bus_t bus_oe_n_o,
  output logic irq_o
);
  import irs_pkg::*;

  irs_bus_t sync1_reg;
  irs_bus_t sync2_reg;
  irs_bus_t prev_reg;
  irs_state_t state_reg;
  logic [7:0] baud_reload_value_reg;
  logic [7:0] cnt_reg;
  logic cnt_run_reg;
  logic repeated_start_request_reg;
  logic stop_request_reg;
  logic [ST_WIDTH-1:0] stat_reg;
  logic [ST_WIDTH-1:0] mask_reg;
  logic drv_scl_low_reg;
  logic drv_sda_low_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  logic scl_s;
  logic sda_s;
  logic tick;
  logic load;
  logic coll;
  logic done_ev;
  logic start_seen;
  logic wr_go;
  logic rd_go;
  logic ctrl_wr;
  logic stat_wr;
  logic [31:0] wmask;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CTRL_OFF) || (a == BAUD_OFF) || (a == STAT_OFF) ||
                (a == MASK_OFF) || (a == STATE_OFF);
  endfunction

  // Two-flop synchroniser on the bus lines
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= '{scl: 1'b1, sda: 1'b1};
      sync2_reg <= '{scl: 1'b1, sda: 1'b1};
      prev_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      sync1_reg <= bus_in_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign scl_s = sync2_reg.scl;
  assign sda_s = sync2_reg.sda;
  assign start_seen = prev_reg.sda && !sda_s && scl_s && prev_reg.scl;

  // Baud divider: tick when the loaded count reaches zero
  assign tick = cnt_run_reg && (cnt_reg == 8'h00);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 8'h00;
      cnt_run_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= baud_reload_value_reg;
      cnt_run_reg <= 1'b1;
    end else if (tick || coll) begin
      cnt_run_reg <= 1'b0;
    end else if (cnt_run_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Sequencer load, collision and completion decisions
  always_comb begin
    load = 1'b0;
    coll = 1'b0;
    done_ev = 1'b0;
    case (state_reg)
      IRS_RS_SCL_LOW: begin
        load = !scl_s && !cnt_run_reg;
      end
      IRS_RS_SDA_HIGH: begin
        coll = tick && !sda_s;
      end
      IRS_RS_SCL_RISE: begin
        // SDA must be high at rise
        coll = scl_s && !sda_s;
        load = scl_s && !cnt_run_reg && !coll;
      end
      IRS_RS_BOTH_HIGH: begin
        coll = !scl_s || !sda_s;
        load = tick && !coll;
      end
      IRS_RS_SDA_LOW: begin
        coll = !scl_s;
        done_ev = tick && !coll;
      end
      IRS_SP_SCL_RISE: begin
        load = scl_s && !cnt_run_reg;
      end
      IRS_SP_COUNT: begin
        coll = !scl_s;
        load = tick && !coll;
      end
      IRS_SP_SDA_REL: begin
        coll = tick && !sda_s;
        done_ev = tick && sda_s;
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= IRS_IDLE;
      drv_scl_low_reg <= 1'b0;
      drv_sda_low_reg <= 1'b0;
    end else if (coll) begin
      state_reg <= IRS_IDLE;
      drv_scl_low_reg <= 1'b0;
      drv_sda_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        IRS_IDLE: begin
          if (repeated_start_request_reg) begin
            drv_scl_low_reg <= 1'b1;
            state_reg <= IRS_RS_SCL_LOW;
          end else if (stop_request_reg) begin
            drv_sda_low_reg <= 1'b1;
            state_reg <= IRS_SP_SDA_LOW;
          end
        end
        IRS_RS_SCL_LOW: begin
          if (load) begin
            drv_sda_low_reg <= 1'b0;
            state_reg <= IRS_RS_SDA_HIGH;
          end
        end
        IRS_RS_SDA_HIGH: begin
          if (tick) begin
            drv_scl_low_reg <= 1'b0;
            state_reg <= IRS_RS_SCL_RISE;
          end
        end
        IRS_RS_SCL_RISE: begin
          if (load) begin
            state_reg <= IRS_RS_BOTH_HIGH;
          end
        end
        IRS_RS_BOTH_HIGH: begin
          if (tick) begin
            drv_sda_low_reg <= 1'b1;
            state_reg <= IRS_RS_SDA_LOW;
          end
        end
        IRS_RS_SDA_LOW: begin
          if (tick) begin
            drv_scl_low_reg <= 1'b1;
            state_reg <= IRS_IDLE;
          end
        end
        IRS_SP_SDA_LOW: begin
          if (!sda_s) begin
            drv_scl_low_reg <= 1'b0;
            state_reg <= IRS_SP_SCL_RISE;
          end
        end
        IRS_SP_SCL_RISE: begin
          if (load) begin
            state_reg <= IRS_SP_COUNT;
          end
        end
        IRS_SP_COUNT: begin
          if (tick) begin
            drv_sda_low_reg <= 1'b0;
            state_reg <= IRS_SP_SDA_REL;
          end
        end
        IRS_SP_SDA_REL: begin
          state_reg <= tick ? IRS_IDLE : IRS_SP_SDA_REL;
        end
        default: begin
          state_reg <= IRS_IDLE;
        end
      endcase
    end
  end

  assign bus_out_o = '{scl: 1'b0, sda: 1'b0};
  assign bus_oe_n_o = '{scl: !drv_scl_low_reg, sda: !drv_sda_low_reg};

  // AXI4-Lite write path
  assign s_axi_awready_o = !aw_got_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_got_reg && !s_axi_bvalid_o;
  assign wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid_o;
  assign wmask = strb_mask(w_strb_reg);
  assign ctrl_wr = wr_go && (aw_addr_reg == CTRL_OFF);
  assign stat_wr = wr_go && (aw_addr_reg == STAT_OFF);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_mapped(aw_addr_reg) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_reload_value_reg <= BAUD_RESET;
      mask_reg <= '0;
    end else if (wr_go && wmask[0]) begin
      if (aw_addr_reg == BAUD_OFF) baud_reload_value_reg <= w_data_reg[7:0];
      if (aw_addr_reg == MASK_OFF) mask_reg <= w_data_reg[ST_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      repeated_start_request_reg <= 1'b0;
      stop_request_reg <= 1'b0;
    end else begin
      if ((state_reg == IRS_RS_SDA_LOW && tick) || coll) begin
        repeated_start_request_reg <= 1'b0;
      end else if (ctrl_wr && wmask[0] && w_data_reg[CTRL_RSTART_BIT]) begin
        if (state_reg == IRS_IDLE) repeated_start_request_reg <= 1'b1;
      end
      if (state_reg == IRS_SP_SDA_REL && (tick || coll)) begin
        stop_request_reg <= 1'b0;
      end else if (state_reg == IRS_SP_COUNT && coll) begin
        stop_request_reg <= 1'b0;
      end else if (ctrl_wr && wmask[0] && w_data_reg[CTRL_STOP_BIT] &&
                   state_reg == IRS_IDLE && !repeated_start_request_reg) begin
        stop_request_reg <= 1'b1;
      end
    end
  end

  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_reg <= '0;
    end else begin
      for (int i = 0; i < ST_WIDTH; i++) begin
        if (stat_wr && wmask[0] && w_data_reg[i]) stat_reg[i] <= 1'b0;
      end
      if (start_seen) stat_reg[ST_START_BIT] <= 1'b1;
      if (done_ev) stat_reg[ST_DONE_BIT] <= 1'b1;
      if (coll) stat_reg[ST_COLL_BIT] <= 1'b1;
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  // AXI4-Lite read path
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= AXI_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= is_mapped(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
      case (s_axi_araddr_i)
        CTRL_OFF: s_axi_rdata_o <= {30'h0, stop_request_reg,
                                    repeated_start_request_reg};
        BAUD_OFF: s_axi_rdata_o <= {24'h0, baud_reload_value_reg};
        STAT_OFF: s_axi_rdata_o <= {29'h0, stat_reg};
        MASK_OFF: s_axi_rdata_o <= {29'h0, mask_reg};
        STATE_OFF: s_axi_rdata_o <= {22'h0, state_reg};
        default: s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### irs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module irs_checker (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire irs_pkg::irs_bus_t bus_in_i,
  input wire irs_pkg::irs_bus_t bus_out_o,
  input wire irs_pkg::irs_bus_t bus_oe_n_o,
  input wire logic irq_o
);
  import irs_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic wr_hs;
  logic [7:0] baud_q;
  logic [8:0] cnt_q;
  assign wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
                 s_axi_wready_o && s_axi_wstrb_i[0];
  // Track the reload value so the start hold can be timed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_q <= BAUD_RESET;
    end else if (wr_hs && s_axi_awaddr_i == BAUD_OFF) begin
      baud_q <= s_axi_wdata_i[7:0];
    end
  end
  // Cycles with SDA pulled while SCL is released
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 9'h0;
    end else begin
      cnt_q <= (bus_oe_n_o == 2'h2) ? cnt_q + 9'h1 : 9'h0;
    end
  end
  property p_out_low;
    bus_out_o == 2'h0;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("bus output not low");
  property p_rs_sda_first;
    $fell(bus_oe_n_o.scl) && bus_oe_n_o.sda |-> bus_oe_n_o.sda [*3];
  endproperty
  a_rs_sda_first: assert property (p_rs_sda_first)
    else $error("sda not released while scl low");
  property p_both_high;
    $fell(bus_oe_n_o.sda) && bus_oe_n_o.scl |-> $past(bus_in_i, 3) == 2'h3;
  endproperty
  a_both_high: assert property (p_both_high)
    else $error("start driven without both lines high");
  property p_start_hold;
    $fell(bus_oe_n_o.scl) && !bus_oe_n_o.sda |->
      cnt_q >= baud_q + 9'h1 && cnt_q <= baud_q + 9'h3;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start hold length wrong");
  property p_rs_end_sda;
    $fell(bus_oe_n_o.scl) && !bus_oe_n_o.sda |=> !bus_oe_n_o.sda;
  endproperty
  a_rs_end_sda: assert property (p_rs_end_sda)
    else $error("sda not held low after start");
  property p_stop_order;
    $rose(bus_oe_n_o.sda) && bus_oe_n_o.scl && !$rose(bus_oe_n_o.scl)
      |-> $past(bus_oe_n_o.scl, 3);
  endproperty
  a_stop_order: assert property (p_stop_order)
    else $error("sda released too soon after scl");
  property p_mask_off;
    wr_hs && s_axi_awaddr_i == MASK_OFF && s_axi_wdata_i[2:0] == 3'h0
      |-> ##2 !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("irq high with mask cleared");
  property p_rvalid;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read answer late");
endmodule
bind irs_top irs_checker u_irs_checker (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
  .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .bus_in_i(bus_in_i), .bus_out_o(bus_out_o), .bus_oe_n_o(bus_oe_n_o),
  .irq_o(irq_o)
);
`default_nettype wire

// ### irs_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module irs_bus_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire irs_pkg::irs_bus_t oe_n_i,
  input wire irs_pkg::irs_bus_t pull_i,
  input wire logic [7:0] stretch_i,
  output irs_pkg::irs_bus_t line_o
);
  import irs_pkg::*;
  logic [7:0] hold_reg;
  logic scl_reg;
  // Slave stretches SCL after each release
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_reg <= 8'h0;
      scl_reg <= 1'h1;
    end else begin
      scl_reg <= oe_n_i.scl;
      if (oe_n_i.scl && !scl_reg) begin
        hold_reg <= stretch_i;
      end else if (hold_reg != 8'h0) begin
        hold_reg <= hold_reg - 8'h1;
      end
    end
  end
  // Pull-ups: a released line reads high
  assign line_o = '{
    scl: oe_n_i.scl & scl_reg & (hold_reg == 8'h0) & ~pull_i.scl,
    sda: oe_n_i.sda & ~pull_i.sda
  };
endmodule
`default_nettype wire

// ### irs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irs_top_tb;
  import irs_pkg::*;
  logic core_clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, irq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  irs_bus_t bus_in_i, bus_out_o, bus_oe_n_o;
  irs_bus_t pull = 2'h0;
  logic [7:0] stretch = 8'h0;
  logic [31:0] m [4];
  int n_errors = 0, compares = 0;
  always #10 core_clk_i = ~core_clk_i;
  irs_top u_irs_top (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .bus_in_i(bus_in_i),
    .bus_out_o(bus_out_o), .bus_oe_n_o(bus_oe_n_o), .irq_o(irq_o)
  );
  irs_bus_model u_irs_bus_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .oe_n_i(bus_oe_n_o), .pull_i(pull), .stretch_i(stretch),
    .line_o(bus_in_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o) begin
        chk({30'h0, s_axi_bresp_o}, {30'h0, er});
        s_axi_bready_i <= 1'h0;
        return;
      end
    end
    chk(32'h0, 32'h1);
    conclude();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er, input logic [31:0] msk);
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o) begin
        chk(s_axi_rdata_o & msk, ed);
        chk({30'h0, s_axi_rresp_o}, {30'h0, er});
        s_axi_rready_i <= 1'h0;
        return;
      end
    end
    chk(32'h0, 32'h1);
    conclude();
  endtask
  // Bounded wait on the drivers (0), the lines (1) or the interrupt (2)
  task automatic wt(input int sel, input logic [1:0] v);
    for (int n = 0; n < 3000; n++) begin
      @(posedge core_clk_i);
      if (sel == 0 && bus_oe_n_o === v) return;
      if (sel == 1 && bus_in_i === v) return;
      if (sel == 2 && {1'h0, irq_o} === v) return;
    end
    chk(32'h0, 32'h1);
    conclude();
  endtask
  task automatic coll_end();
    wt(2, 2'h1);
    pull <= 2'h0;
    rd(STAT_OFF, 32'h4, AXI_OKAY, 32'h4);
    rd(CTRL_OFF, 32'h0, AXI_OKAY, 32'h3);
    rd(STATE_OFF, {22'h0, IRS_IDLE}, AXI_OKAY, 32'hffffffff);
    chk({30'h0, bus_oe_n_o}, 32'h3);
    chk({30'h0, bus_out_o}, 32'h0);
    wr(STAT_OFF, 32'h7, AXI_OKAY);
  endtask
  initial begin
    m[0] = 32'h0;
    m[1] = {24'h0, BAUD_RESET};
    m[2] = 32'h0;
    m[3] = 32'h0;
    void'($urandom(32'h408f2bda));
    stretch = 8'($urandom_range(12, 3));
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'h1;
    for (int i = 0; i < 4; i++) rd(8'(4 * i), m[i], AXI_OKAY, 32'hffffffff);
    rd(8'h14, 32'h0, AXI_SLVERR, 32'hffffffff);
    wr(8'h14, 32'h1, AXI_SLVERR);
    m[1] = $urandom_range(6, 1);
    wr(BAUD_OFF, m[1], AXI_OKAY);
    rd(BAUD_OFF, m[1], AXI_OKAY, 32'hffffffff);
    wr(MASK_OFF, 32'h7, AXI_OKAY);
    wr(CTRL_OFF, 32'h1, AXI_OKAY);
    wt(0, 2'h1);
    wt(0, 2'h3);
    wt(0, 2'h2);
    wt(0, 2'h0);
    rd(CTRL_OFF, 32'h0, AXI_OKAY, 32'h1);
    rd(STAT_OFF, 32'h3, AXI_OKAY, 32'h7);
    chk({31'h0, irq_o}, 32'h1);
    wr(MASK_OFF, 32'h0, AXI_OKAY);
    rd(STAT_OFF, 32'h3, AXI_OKAY, 32'h7);
    chk({31'h0, irq_o}, 32'h0);
    wr(MASK_OFF, 32'h7, AXI_OKAY);
    rd(STAT_OFF, 32'h3, AXI_OKAY, 32'h7);
    chk({31'h0, irq_o}, 32'h1);
    wr(STAT_OFF, 32'h7, AXI_OKAY);
    rd(STAT_OFF, 32'h0, AXI_OKAY, 32'h7);
    chk({31'h0, irq_o}, 32'h0);
    // Stop with another master holding SDA after release
    wr(CTRL_OFF, 32'h2, AXI_OKAY);
    wt(0, 2'h2);
    pull.sda <= 1'h1;
    wr(CTRL_OFF, 32'h1, AXI_OKAY);
    wt(0, 2'h3);
    coll_end();
    // SDA low when SCL rises, SCL held by the stretching slave
    wr(CTRL_OFF, 32'h1, AXI_OKAY);
    wt(0, 2'h1);
    wt(0, 2'h3);
    pull.sda <= 1'h1;
    coll_end();
    // SCL pulled low after it was seen high, before SDA is asserted
    wr(BAUD_OFF, 32'h8, AXI_OKAY);
    wr(CTRL_OFF, 32'h1, AXI_OKAY);
    wt(0, 2'h1);
    wt(0, 2'h3);
    wt(1, 2'h3);
    @(posedge core_clk_i);
    pull.scl <= 1'h1;
    coll_end();
    conclude();
  end
endmodule
`default_nettype wire
